// ---- sdls_consts.svh ----
`ifndef SDLS_CONSTS_SVH
`define SDLS_CONSTS_SVH

// ************************************************************
// Timing
// ************************************************************
`define SDLS_CLK_HZ 125000000
`define SDLS_MS_PER_S 1000
`define SDLS_CYCLES_PER_MS (`SDLS_CLK_HZ / `SDLS_MS_PER_S)
`define SDLS_OFF_LIMIT_S 2
`define SDLS_OFF_LIMIT_MS (`SDLS_OFF_LIMIT_S * `SDLS_MS_PER_S)

// ************************************************************
// Level ratios in percent of nominal current
// ************************************************************
`define SDLS_RATIO_FULL 7'h64
`define SDLS_RATIO_M1_L2 7'h32
`define SDLS_RATIO_M1_L3 7'h14
`define SDLS_RATIO_M2_L2 7'h3C
`define SDLS_RATIO_M2_L3 7'h1E
`define SDLS_RATIO_M3_L2 7'h1E

// ************************************************************
// Thermal thresholds in degrees C and kelvin
// ************************************************************
`define SDLS_TEMP_TRIP 8'h96
`define SDLS_TEMP_HYST 8'h14

`endif

// ---- sdls_mains_switch.sv ----
`default_nettype none

// ************************************************************
// Wall switch on the supply line
// ************************************************************
module sdls_mains_switch (
   // Clock used only to place the edges
   input wire logic core_clk,
   // Supply line towards the device
   output logic supply_sense
);
   timeunit 1ns;
   timeprecision 1ps;

   initial supply_sense = 1'b1;

   // Edges land on falling clock edges, well clear of the sampling edge
   task automatic set_line(input logic level);
      @(negedge core_clk);
      supply_sense = level;
   endtask

   // One switch action; off span in clock cycles, never a glitch
   task automatic toggle(input int unsigned off_cycles);
      set_line(1'b0);
      repeat (off_cycles) @(negedge core_clk);
      supply_sense = 1'b1;
   endtask
endmodule

`default_nettype wire

// ---- sdls_pkg.sv ----
`default_nettype none

package sdls_pkg;
   typedef enum logic [1:0] {
      SDLS_MODE_NONE,
      SDLS_MODE_1,
      SDLS_MODE_2,
      SDLS_MODE_3
   } sdls_mode_t;

   typedef enum logic [1:0] {
      SDLS_LEVEL1,
      SDLS_LEVEL2,
      SDLS_LEVEL3
   } sdls_step_t;

   typedef logic [7:0] sdls_temp_t;
   typedef logic [6:0] sdls_ratio_t;
endpackage

`default_nettype wire

// ---- sdls_sequencer.sv ----
// Overview of operation
// RULE1: After power-up reset the level is full nominal current.
// RULE2: Each dimming switch action advances to the next level of the mode.
// RULE3: A dimming action at the lowest level wraps back to full current.
// RULE4: Supply off longer than the timeout clears the level to full.
// RULE5: Off-time over 2 s is a normal switch, under 2 s a dimming one.
// RULE6: Normal switch or both selects floating forces full current.
// RULE7: Select pins decode into modes 1, 2 and 3 with their ratios.
// RULE8: Mode 2 steps full, 60 percent, 30 percent, then full again.
// RULE9: Off-time keeps being measured while supply is absent.
// RULE10: Over-temperature above the trip point stops the output.
// RULE11: Output resumes only below trip point minus 20 K.
// RULE12: Level leaves as a ratio code; thermal state gates switch drive.
`include "sdls_consts.svh"
`default_nettype none

module sdls_sequencer #(
   parameter int unsigned CYCLES_PER_MS = `SDLS_CYCLES_PER_MS,
   parameter int unsigned OFF_LIMIT_MS = `SDLS_OFF_LIMIT_MS
) (
   // Clock and power-up reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Pins: supply sense, level selects (1 = floating), die temperature
   input wire logic supply_sense,
   input wire logic level_select_a,
   input wire logic level_select_b,
   input wire sdls_pkg::sdls_temp_t die_temp,
   // To the current loop and output switch
   output sdls_pkg::sdls_ratio_t level_ratio,
   output logic switch_drive_enable
);
   import sdls_pkg::*;

   localparam int DIV_W = $clog2(CYCLES_PER_MS);
   localparam int OFF_W = $clog2(OFF_LIMIT_MS + 1);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Temperature moves far slower than the clock, so a bitwise
   // two-flop capture is adequate; a torn code lasts one cycle.
   logic sync_supply, supply_on;
   logic sync_sel_a, sel_a, sync_sel_b, sel_b;
   sdls_temp_t sync_temp, temp_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sync_supply <= 1'b0;
         supply_on <= 1'b0;
         sync_sel_a <= 1'b1;
         sel_a <= 1'b1;
         sync_sel_b <= 1'b1;
         sel_b <= 1'b1;
         sync_temp <= 8'h00;
         temp_q <= 8'h00;
      end else begin
         sync_supply <= supply_sense;
         supply_on <= sync_supply;
         sync_sel_a <= level_select_a;
         sel_a <= sync_sel_a;
         sync_sel_b <= level_select_b;
         sel_b <= sync_sel_b;
         sync_temp <= die_temp;
         temp_q <= sync_temp;
      end
   end

   // ************************************************************
   // Thermal gate
   // ************************************************************
   sdls_thermal_if thermal ();
   assign thermal.die_temp = temp_q;

   sdls_thermal_gate u_thermal (
      .core_clk (core_clk),
      .reset_n (reset_n),
      .thermal (thermal)
   );

   // ************************************************************
   // Mode decode
   // ************************************************************
   sdls_mode_t mode;

   always_comb begin
      unique case ({sel_a, sel_b}) // RULE7
         2'b11: mode = SDLS_MODE_NONE;
         2'b10: mode = SDLS_MODE_1;
         2'b01: mode = SDLS_MODE_2;
         2'b00: mode = SDLS_MODE_3;
      endcase
   end

   // ************************************************************
   // Off-time measurement and level stepping
   // ************************************************************
   logic [DIV_W-1:0] ms_div, next_ms_div;
   logic [OFF_W-1:0] off_ms, next_off_ms;
   logic expired, next_expired;
   logic seen_off, next_seen_off;
   logic supply_prev, next_supply_prev;
   sdls_step_t step, next_step;
   sdls_ratio_t next_level_ratio;
   logic next_drive;
   logic supply_rise, supply_fall, ms_tick, off_full;

   assign supply_rise = supply_on && !supply_prev;
   assign supply_fall = !supply_on && supply_prev;
   assign ms_tick = ms_div == DIV_W'(CYCLES_PER_MS - 1);
   assign off_full = off_ms == OFF_W'(OFF_LIMIT_MS);

   always_comb begin
      next_ms_div = ms_div;
      next_off_ms = off_ms;
      next_expired = expired;
      next_seen_off = seen_off;
      next_supply_prev = supply_on;
      next_step = step;
      if (supply_fall) begin
         next_ms_div = '0;
         next_off_ms = '0;
         next_expired = 1'b0;
         next_seen_off = 1'b1;
      end else if (!supply_on) begin
         // Runs on stored charge; counting continues while off
         next_ms_div = ms_tick ? '0 : ms_div + 1'b1; // RULE9
         if (ms_tick && !off_full) begin
            next_off_ms = off_ms + 1'b1; // RULE9
         end
         if (ms_tick && off_full) begin
            next_expired = 1'b1; // RULE5
         end
      end
      if (expired) begin
         next_step = SDLS_LEVEL1; // RULE4
      end
      // First power-up is not a switch action: a fall must come first
      if (supply_rise && seen_off && !expired) begin
         unique case (step) // RULE2
            SDLS_LEVEL1: next_step = SDLS_LEVEL2;
            SDLS_LEVEL2: next_step = (mode == SDLS_MODE_3) ?
                                     SDLS_LEVEL1 : SDLS_LEVEL3; // RULE3
            SDLS_LEVEL3: next_step = SDLS_LEVEL1; // RULE3
            default: next_step = SDLS_LEVEL1;
         endcase
      end
      if (mode == SDLS_MODE_NONE) begin
         next_step = SDLS_LEVEL1; // RULE6
      end
   end

   always_comb begin
      next_level_ratio = `SDLS_RATIO_FULL;
      unique case (step) // RULE12
         SDLS_LEVEL1: next_level_ratio = `SDLS_RATIO_FULL;
         SDLS_LEVEL2: begin
            unique case (mode)
               SDLS_MODE_1: next_level_ratio = `SDLS_RATIO_M1_L2;
               SDLS_MODE_2: next_level_ratio = `SDLS_RATIO_M2_L2; // RULE8
               SDLS_MODE_3: next_level_ratio = `SDLS_RATIO_M3_L2;
               SDLS_MODE_NONE: next_level_ratio = `SDLS_RATIO_FULL;
            endcase
         end
         SDLS_LEVEL3: begin
            unique case (mode)
               SDLS_MODE_1: next_level_ratio = `SDLS_RATIO_M1_L3;
               SDLS_MODE_2: next_level_ratio = `SDLS_RATIO_M2_L3; // RULE8
               SDLS_MODE_3, SDLS_MODE_NONE:
                  next_level_ratio = `SDLS_RATIO_FULL;
            endcase
         end
         default: next_level_ratio = `SDLS_RATIO_FULL;
      endcase
      next_drive = supply_on && !thermal.over_temp; // RULE12
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ms_div <= '0;
         off_ms <= '0;
         expired <= 1'b0;
         seen_off <= 1'b0;
         supply_prev <= 1'b0;
         step <= SDLS_LEVEL1; // RULE1
         level_ratio <= `SDLS_RATIO_FULL; // RULE1
         switch_drive_enable <= 1'b0;
      end else begin
         ms_div <= next_ms_div;
         off_ms <= next_off_ms;
         expired <= next_expired;
         seen_off <= next_seen_off;
         supply_prev <= next_supply_prev;
         step <= next_step;
         level_ratio <= next_level_ratio;
         switch_drive_enable <= next_drive;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_powerup;
      @(posedge core_clk) disable iff (!reset_n)
      !$past(reset_n) |-> step == SDLS_LEVEL1 &&
                          level_ratio == `SDLS_RATIO_FULL;
   endproperty
   a_powerup: assert property (p_powerup) else $error("Bad start level"); // RULE1

   sequence s_dim_action;
      supply_rise && seen_off && !expired && mode != SDLS_MODE_NONE;
   endsequence

   property p_advance;
      @(posedge core_clk) disable iff (!reset_n)
      s_dim_action ##0 step == SDLS_LEVEL1 |=> step == SDLS_LEVEL2;
   endproperty
   a_advance: assert property (p_advance) else $error("No advance"); // RULE2

   property p_wrap;
      @(posedge core_clk) disable iff (!reset_n)
      s_dim_action ##0 (step == SDLS_LEVEL3 ||
         (step == SDLS_LEVEL2 && mode == SDLS_MODE_3))
      |=> step == SDLS_LEVEL1;
   endproperty
   a_wrap: assert property (p_wrap) else $error("No wrap"); // RULE3

   property p_timeout;
      @(posedge core_clk) disable iff (!reset_n)
      !supply_on && !supply_fall && ms_tick && off_full
      |=> expired ##1 step == SDLS_LEVEL1;
   endproperty
   a_timeout: assert property (p_timeout) else $error("No timeout"); // RULE4

   property p_normal;
      @(posedge core_clk) disable iff (!reset_n)
      supply_rise && expired |=> step == SDLS_LEVEL1;
   endproperty
   a_normal: assert property (p_normal) else $error("Normal not full"); // RULE5

   property p_float;
      @(posedge core_clk) disable iff (!reset_n)
      mode == SDLS_MODE_NONE |=> step == SDLS_LEVEL1 ##1
                                 level_ratio == `SDLS_RATIO_FULL;
   endproperty
   a_float: assert property (p_float) else $error("Dimmed unconfigured"); // RULE6

   property p_mode2;
      @(posedge core_clk) disable iff (!reset_n)
      step == SDLS_LEVEL2 && mode == SDLS_MODE_2
      |=> level_ratio == `SDLS_RATIO_M2_L2;
   endproperty
   a_mode2: assert property (p_mode2) else $error("Mode 2 ratio"); // RULE8

   property p_count;
      @(posedge core_clk) disable iff (!reset_n)
      !supply_on && !supply_fall && ms_tick && !off_full
      |=> off_ms == $past(off_ms) + 1'b1;
   endproperty
   a_count: assert property (p_count) else $error("Off count stalled"); // RULE9

   property p_gate;
      @(posedge core_clk) disable iff (!reset_n)
      thermal.over_temp |=> !switch_drive_enable;
   endproperty
   a_gate: assert property (p_gate) else $error("Drive when hot"); // RULE12
endmodule

`default_nettype wire

// ---- sdls_thermal_gate.sv ----
`include "sdls_consts.svh"
`default_nettype none

module sdls_thermal_gate (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Temperature in, shutdown out
   sdls_thermal_if.gate thermal
);
   import sdls_pkg::*;

   logic over_temp;
   logic next_over_temp;
   sdls_temp_t release_point;

   assign release_point = `SDLS_TEMP_TRIP - `SDLS_TEMP_HYST;

   // ************************************************************
   // Shutdown with hysteresis
   // ************************************************************
   always_comb begin
      next_over_temp = over_temp;
      if (thermal.die_temp > `SDLS_TEMP_TRIP) begin
         next_over_temp = 1'b1; // RULE10
      end else if (thermal.die_temp < release_point) begin
         next_over_temp = 1'b0; // RULE11
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         over_temp <= 1'b0;
      end else begin
         over_temp <= next_over_temp;
      end
   end

   assign thermal.over_temp = over_temp;

   // ************************************************************
   // Checks
   // ************************************************************
   property p_trip;
      @(posedge core_clk) disable iff (!reset_n)
      thermal.die_temp > `SDLS_TEMP_TRIP |=> over_temp;
   endproperty
   a_trip: assert property (p_trip) else $error("No trip above limit"); // RULE10

   property p_hold_off;
      @(posedge core_clk) disable iff (!reset_n)
      over_temp && thermal.die_temp >= release_point |=> over_temp;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("Released early"); // RULE11
endmodule

`default_nettype wire

// ---- sdls_thermal_if.sv ----
`default_nettype none

interface sdls_thermal_if;
   import sdls_pkg::*;
   sdls_temp_t die_temp;
   logic over_temp;

   modport seq (output die_temp, input over_temp);
   modport gate (input die_temp, output over_temp);
endinterface

`default_nettype wire

// ---- switch_dimming_level_sequencer_tb.sv ----
`include "sdls_consts.svh"
`default_nettype none

// ************************************************************
// Bench
// ************************************************************
module switch_dimming_level_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sdls_pkg::*;

   // Short counts: limit is 5 ms of 4 cycles, so 20 cycles off
   localparam int unsigned CPM = 4;
   localparam int unsigned LIM = 5;
   localparam int unsigned DIM_OFF = 8;
   localparam int unsigned LONG_OFF = 40;

`define SDLS_CHECK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
   end \
end

   logic core_clk;
   logic reset_n;
   logic supply_sense;
   logic level_select_a;
   logic level_select_b;
   sdls_temp_t die_temp;
   sdls_ratio_t level_ratio;
   logic switch_drive_enable;
   int error_cnt = 0;
   int n_checks = 0;

   sdls_mains_switch mains_u (
      .core_clk(core_clk),
      .supply_sense(supply_sense)
   );

   sdls_sequencer #(.CYCLES_PER_MS(CPM), .OFF_LIMIT_MS(LIM)) dut_u (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .supply_sense(supply_sense),
      .level_select_a(level_select_a),
      .level_select_b(level_select_b),
      .die_temp(die_temp),
      .level_ratio(level_ratio),
      .switch_drive_enable(switch_drive_enable)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Waits cover the syncs plus the registered outputs
   task automatic settle;
      repeat (10) @(negedge core_clk);
   endtask

   task automatic act(input int unsigned off);
      mains_u.toggle(off);
      settle();
   endtask

   task automatic pick(input logic a, input logic b);
      @(negedge core_clk);
      level_select_a = a;
      level_select_b = b;
      settle();
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic test_no_dim;
      pick(1'b1, 1'b1);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
      `SDLS_CHECK(switch_drive_enable, 1'b1)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
   endtask

   task automatic test_mode2;
      pick(1'b0, 1'b1);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M2_L2)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M2_L3)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
   endtask

   task automatic test_mode1;
      pick(1'b1, 1'b0);
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M1_L2)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M1_L3)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
   endtask

   task automatic test_mode3;
      pick(1'b0, 1'b0);
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M3_L2)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
   endtask

   task automatic test_timeout;
      pick(1'b0, 1'b1);
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M2_L2)
      act(LONG_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
      act(DIM_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M2_L2)
      act(LONG_OFF);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
   endtask

   task automatic test_thermal;
      mains_u.set_line(1'b0);
      settle();
      `SDLS_CHECK(switch_drive_enable, 1'b0)
      mains_u.set_line(1'b1);
      settle();
      die_temp = `SDLS_TEMP_TRIP;
      settle();
      `SDLS_CHECK(switch_drive_enable, 1'b1)
      die_temp = `SDLS_TEMP_TRIP + 8'h01;
      settle();
      `SDLS_CHECK(switch_drive_enable, 1'b0)
      die_temp = `SDLS_TEMP_TRIP - `SDLS_TEMP_HYST;
      settle();
      `SDLS_CHECK(switch_drive_enable, 1'b0)
      die_temp = `SDLS_TEMP_TRIP - `SDLS_TEMP_HYST - 8'h01;
      settle();
      `SDLS_CHECK(switch_drive_enable, 1'b1)
      // Short dip above was a dimming action; heat must not clear it
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_M2_L2)
   endtask

   initial begin
      reset_n = 1'b0;
      level_select_a = 1'b1;
      level_select_b = 1'b1;
      die_temp = 8'h19;
      repeat (3) @(negedge core_clk);
      `SDLS_CHECK(level_ratio, `SDLS_RATIO_FULL)
      `SDLS_CHECK(switch_drive_enable, 1'b0)
      reset_n = 1'b1;
      test_no_dim();
      test_mode2();
      test_mode1();
      test_mode3();
      test_timeout();
      test_thermal();
      final_report();
   end

   // Whole run is well under two thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      final_report();
   end
endmodule

`default_nettype wire
